//--- sac_comp_model.sv
// Comparator stand-in for the converter's analog side.
// Assumes one analog level from the bench, held steady during a conversion.
`timescale 1ns/1ps
module sac_comp_model (
   input wire logic i_clk,
   input wire logic [7:0] i_level,
   input wire logic [7:0] i_dac_code,
   input wire logic i_power,
   output logic o_comp_hi
);
   // ========
   // Comparator
   // ========
   // Single analog source; unpowered output toggles so a stale answer is never trusted
   initial o_comp_hi = 1'b0;
   always @(posedge i_clk) begin
      if (i_power) begin
         o_comp_hi <= (i_level >= i_dac_code);
      end else begin
         o_comp_hi <= ~o_comp_hi;
      end
   end
endmodule // sac_comp_model

//--- sac_pkg.sv
// Shared constants and types for the SAR converter control block.
// Assumes a single 40 MHz clock that also serves as the converter oscillator.
package sac_pkg;

   // ==========================================================================
   // Conversion timing
   // ==========================================================================
   // Oscillator divide ratio for the conversion clock
   localparam int OSC_DIV = 12;
   // Typical conversion time in ns at the reference oscillator rate
   localparam int CONV_TIME_NS = 70000;
   // Reference oscillator rate in kHz at which that time holds
   localparam int REF_OSC_KHZ = 8000;
   // Whole conversion-clock ticks per conversion, rounded down (46)
   localparam int CONV_TICKS_INT = (CONV_TIME_NS * REF_OSC_KHZ) / (OSC_DIV * 1000000);
   localparam int RES_BITS = 8;
   localparam logic [3:0] DIV_LAST = 4'(OSC_DIV - 1);
   localparam logic [5:0] CONV_TICKS = 6'(CONV_TICKS_INT);
   // Ticks spent on each approximation step (5)
   localparam logic [2:0] TICKS_PER_BIT = 3'(CONV_TICKS_INT / RES_BITS);
   localparam logic [7:0] TRIAL_MSB = 8'h80;

   // ==========================================================================
   // Register map: indices, byte address is four times the index
   // ==========================================================================
   localparam logic [7:0] IDX_RESULT = 8'hD0;
   localparam logic [7:0] IDX_CONTROL = 8'hD1;
   localparam logic [7:0] IDX_EVT_STATUS = 8'hD2;
   localparam logic [7:0] IDX_EVT_MASK = 8'hD3;
   localparam int ADDR_W = 12;

   // Control register bit positions and reset value
   localparam int BIT_IRQ_EN = 7;
   localparam int BIT_DONE = 6;
   localparam int BIT_START = 5;
   localparam int BIT_POWER = 4;
   localparam logic [7:0] CTRL_RESET = 8'h40;

   // Event status bits: conversion complete, conversion abandoned by restart
   localparam int EVT_W = 2;
   localparam int EVT_DONE = 0;
   localparam int EVT_RESTART = 1;
   localparam logic [1:0] EVT_MASK_RESET = 2'h1;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {
      SAC_SEL_RESULT,
      SAC_SEL_CONTROL,
      SAC_SEL_STATUS,
      SAC_SEL_MASK,
      SAC_SEL_NONE
   } sac_sel_t;

   // Request from the register side to the approximation engine
   typedef struct packed {
      logic start;
      logic abort;
      logic comp_hi;
   } sac_eng_req_t;

   // Answer from the approximation engine
   typedef struct packed {
      logic busy;
      logic done;
      logic [7:0] result;
      logic [7:0] trial;
   } sac_eng_rsp_t;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] sac_byte_addr(input logic [7:0] idx);
      sac_byte_addr = {2'h0, idx, 2'h0};
   endfunction

   // Decode a bus address into a register select
   function automatic sac_sel_t sac_decode(input logic [ADDR_W-1:0] addr);
      if (addr == sac_byte_addr(IDX_RESULT)) begin
         sac_decode = SAC_SEL_RESULT;
      end else if (addr == sac_byte_addr(IDX_CONTROL)) begin
         sac_decode = SAC_SEL_CONTROL;
      end else if (addr == sac_byte_addr(IDX_EVT_STATUS)) begin
         sac_decode = SAC_SEL_STATUS;
      end else if (addr == sac_byte_addr(IDX_EVT_MASK)) begin
         sac_decode = SAC_SEL_MASK;
      end else begin
         sac_decode = SAC_SEL_NONE;
      end
   endfunction

endpackage

//--- sac_sar_engine.sv
// Successive-approximation sequencer with its own divide-by-twelve tick.
// Assumes start and abort are single-clock pulses/levels from the register side.
`timescale 1ns/1ps
module sac_sar_engine
   import sac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire sac_eng_req_t i_req,
   output sac_eng_rsp_t o_rsp
);

   typedef enum {ENG_IDLE, ENG_CONV} sac_eng_state_t;

   typedef struct packed {
      sac_eng_state_t state;
      logic [3:0] div;
      logic [5:0] tick;
      logic [2:0] step;
      logic [2:0] bitn;
      logic resolving;
      logic [7:0] trial;
      logic [7:0] result;
      logic done;
   } sac_eng_st_t;

   localparam sac_eng_st_t ENG_RST = '{state: ENG_IDLE, div: '0, tick: '0, step: '0, bitn: '0,
                                       resolving: 1'b0, trial: '0, result: '0, done: 1'b0};

   sac_eng_st_t q;
   sac_eng_st_t d;

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (i_req.abort) begin
         // Power off stops everything, trial code parked at zero
         d = ENG_RST;
         d.result = q.result;
      end else if (i_req.start) begin
         // A new start wins unless abort is set, even mid-conversion
         d.state = ENG_CONV;
         d.div = '0;
         d.tick = '0;
         d.step = '0;
         d.bitn = 3'(RES_BITS - 1);
         d.resolving = 1'b1;
         d.trial = TRIAL_MSB;
      end else begin
         case (q.state)
            ENG_CONV: begin
               // Conversion clock is the oscillator divided by twelve
               if (q.div == DIV_LAST) begin
                  d.div = '0;
                  d.tick = q.tick + 6'h1;
                  if (q.resolving) begin
                     if (q.step == TICKS_PER_BIT - 3'h1) begin
                        // Step done: keep or drop the trial bit
                        d.step = '0;
                        if (!i_req.comp_hi) begin
                           d.trial[q.bitn] = 1'b0;
                        end
                        if (q.bitn == 3'h0) begin
                           d.resolving = 1'b0;
                        end else begin
                           d.bitn = q.bitn - 3'h1;
                           d.trial[q.bitn - 3'h1] = 1'b1;
                        end
                     end else begin
                        d.step = q.step + 3'h1;
                     end
                  end
                  // Fixed length, then exactly one done pulse and stop
                  if (q.tick == CONV_TICKS - 6'h1) begin
                     d.state = ENG_IDLE;
                     d.result = q.trial;
                     d.done = 1'b1;
                  end
               end else begin
                  d.div = q.div + 4'h1;
               end
            end
            default: begin
               d.state = ENG_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q <= ENG_RST;
      end else begin
         q <= d;
      end
   end

   // Answer fields are register outputs, except busy, which is decoded from the state register
   assign o_rsp.busy = (q.state == ENG_CONV);
   assign o_rsp.done = q.done;
   assign o_rsp.result = q.result;
   assign o_rsp.trial = q.trial;

endmodule // sac_sar_engine

//--- sac_top.sv
// Register side of the SAR converter control: AXI4-Lite slave, control and
// result registers, event status with mask and one level interrupt.
// Assumes an external comparator and DAC: the DAC shows o_dac_code and the
// comparator answers on i_comp_hi, which arrives asynchronously.
//
// How it works
// - Conversions run on the oscillator divided by twelve and resolve an 8-bit result by successive approximation.
// - A conversion lasts a fixed 46 conversion ticks, about seventy microseconds with an eight megahertz oscillator.
// - Writing one to the start bit, with the power bit one in the same write, begins a conversion and clears the done flag at once.
// - Completing a conversion sets the done flag and the result register holds the new value.
// - One start gives exactly one conversion, and nothing runs again until start is written anew.
// - A start written during a conversion abandons it and begins a fresh one.
// - The start bit is write-only and always reads as zero.
// - A set, unmasked completion event in the event status register raises the converter interrupt request.
// - The interrupt request is masked while the interrupt enable bit is clear.
// - Power bit zero switches the converter off, one powers it and allows conversion.
// - The comparator stays powered in wait mode unless software cleared the power bit.
// - Reset aborts any conversion, loads the control register with 40h and leaves interrupts disabled.
// - The 8-bit result is read from a read-only register at index 0D0h.
// - The control register at index 0D1h holds enable, done, start and power in bits 7 to 4, low bits unused.
`timescale 1ns/1ps
module sac_top
   import sac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_comp_hi,
   output logic [7:0] o_dac_code,
   output logic o_conv_power,
   output logic o_irq
);

   // ==========================================================================
   // State
   // ==========================================================================
   typedef struct packed {
      logic awrdy;
      logic awhave;
      logic [ADDR_W-1:0] awaddr;
      logic wrdy;
      logic whave;
      logic [7:0] wdata;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq_enable;
      logic done;
      logic power_on;
      logic start_pulse;
      logic [EVT_W-1:0] evt_sts;
      logic [EVT_W-1:0] evt_msk;
      logic irq;
      logic comp_meta;
      logic comp_sync;
   } sac_main_st_t;

   // Reset image: control byte 40h means done set, enable, start and power clear
   localparam sac_main_st_t MAIN_RST = '{
      awrdy: 1'b1, awhave: 1'b0, awaddr: '0, wrdy: 1'b1, whave: 1'b0, wdata: '0, wlane: 1'b0,
      bvalid: 1'b0, bresp: RESP_OKAY, arrdy: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY,
      irq_enable: CTRL_RESET[BIT_IRQ_EN], done: CTRL_RESET[BIT_DONE], power_on: CTRL_RESET[BIT_POWER],
      start_pulse: 1'b0, evt_sts: '0, evt_msk: EVT_MASK_RESET, irq: 1'b0,
      comp_meta: 1'b0, comp_sync: 1'b0};

   sac_main_st_t q;
   sac_main_st_t d;
   sac_eng_req_t eng_req;
   sac_eng_rsp_t eng_rsp;

   // ==========================================================================
   // Approximation engine
   // ==========================================================================
   // Engine sees only the synchronised comparator level
   assign eng_req.start = q.start_pulse;
   assign eng_req.abort = ~q.power_on;
   assign eng_req.comp_hi = q.comp_sync;

   sac_sar_engine u_engine (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_req(eng_req),
      .o_rsp(eng_rsp)
   );

   // ==========================================================================
   // Read data assembly
   // ==========================================================================
   // Control byte as software sees it; start always reads zero
   function automatic logic [7:0] ctrl_image(input sac_main_st_t s);
      logic [7:0] v;
      v = '0;
      v[BIT_IRQ_EN] = s.irq_enable;
      v[BIT_DONE] = s.done;
      v[BIT_START] = 1'b0;
      v[BIT_POWER] = s.power_on;
      ctrl_image = v;
   endfunction

   // ==========================================================================
   // Next state
   // ==========================================================================
   always_comb begin
      logic start_wr;
      logic [7:0] wbyte;
      sac_sel_t wsel;
      sac_sel_t rsel;
      start_wr = 1'b0;
      wbyte = '0;
      wsel = SAC_SEL_NONE;
      rsel = SAC_SEL_NONE;
      d = q;
      d.start_pulse = 1'b0;

      // Two flops on the asynchronous comparator answer
      d.comp_meta = i_comp_hi;
      d.comp_sync = q.comp_meta;

      // Write response retires when the master takes it
      if (q.bvalid && i_s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // Address and data are captured independently, in either order
      if (i_s_axi_awvalid && q.awrdy) begin
         d.awhave = 1'b1;
         d.awaddr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && q.wrdy) begin
         d.whave = 1'b1;
         d.wdata = i_s_axi_wdata[7:0];
         d.wlane = i_s_axi_wstrb[0];
      end

      // Perform the write once both halves are held
      if (d.awhave && d.whave && !d.bvalid) begin
         d.awhave = 1'b0;
         d.whave = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         wsel = sac_decode(d.awaddr);
         wbyte = d.wdata;
         if (wsel == SAC_SEL_NONE) begin
            d.bresp = RESP_SLVERR;
         end else if (d.wlane) begin
            case (wsel)
               SAC_SEL_CONTROL: begin
                  d.irq_enable = wbyte[BIT_IRQ_EN];
                  d.power_on = wbyte[BIT_POWER];
                  // Start only takes effect with the converter powered
                  start_wr = wbyte[BIT_START] & wbyte[BIT_POWER];
               end
               SAC_SEL_STATUS: begin
                  d.evt_sts = q.evt_sts & ~wbyte[EVT_W-1:0];
               end
               SAC_SEL_MASK: begin
                  d.evt_msk = wbyte[EVT_W-1:0];
               end
               default: begin
                  // Result register is read-only, writes are dropped
                  d.evt_msk = q.evt_msk;
               end
            endcase
         end
      end

      // Start clears done immediately and kicks the engine next cycle
      if (start_wr) begin
         d.start_pulse = 1'b1;
         d.done = 1'b0;
         if (eng_rsp.busy) begin
            d.evt_sts[EVT_RESTART] = 1'b1;
         end
      end else if (eng_rsp.done && !q.start_pulse) begin
         // Completion flags the result as valid
         d.done = 1'b1;
      end

      // Completion event is sticky; a set beats a same-cycle clear
      if (eng_rsp.done && !q.start_pulse) begin
         d.evt_sts[EVT_DONE] = 1'b1;
      end

      // Interrupt follows the unmasked done and restart events, gated by the enable bit
      d.irq = d.irq_enable & (|(d.evt_sts & d.evt_msk));

      // Read channel: one outstanding read, answered one cycle after acceptance
      if (q.rvalid && i_s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (i_s_axi_arvalid && q.arrdy) begin
         rsel = sac_decode(i_s_axi_araddr);
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         case (rsel)
            SAC_SEL_RESULT: begin
               d.rdata[7:0] = eng_rsp.result;
            end
            SAC_SEL_CONTROL: begin
               d.rdata[7:0] = ctrl_image(q);
            end
            SAC_SEL_STATUS: begin
               d.rdata[EVT_W-1:0] = q.evt_sts;
            end
            SAC_SEL_MASK: begin
               d.rdata[EVT_W-1:0] = q.evt_msk;
            end
            default: begin
               d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Ready flags registered so every bus output leaves a flop
      d.awrdy = ~d.awhave & ~d.bvalid;
      d.wrdy = ~d.whave & ~d.bvalid;
      d.arrdy = ~d.rvalid;
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   // Synchronous reset aborts any conversion and loads control 40h
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         q <= MAIN_RST;
      end else begin
         q <= d;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign o_s_axi_awready = q.awrdy;
   assign o_s_axi_wready = q.wrdy;
   assign o_s_axi_bresp = q.bresp;
   assign o_s_axi_bvalid = q.bvalid;
   assign o_s_axi_arready = q.arrdy;
   assign o_s_axi_rdata = q.rdata;
   assign o_s_axi_rresp = q.rresp;
   assign o_s_axi_rvalid = q.rvalid;
   // Comparator power follows the power bit only; wait mode does not drop it
   assign o_conv_power = q.power_on;
   assign o_dac_code = eng_rsp.trial;
   assign o_irq = q.irq;

endmodule // sac_top

//--- sac_top_props.sv
// Concurrent checks on the ports of the SAR converter control block.
// Assumes the control register at byte address 344h and one clock domain.
`timescale 1ns/1ps
module sac_top_props
   import sac_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_s_axi_rvalid,
   input wire logic [7:0] o_dac_code,
   input wire logic o_conv_power,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   // ========
   // Helpers
   // ========
   logic wr_ctl;
   logic [15:0] since_q;
   logic pw_q;
   logic rd_ctl_q;
   // Control write taken with both halves at one edge, lane 0 enabled
   assign wr_ctl = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
      && i_s_axi_wstrb[0] && (i_s_axi_awaddr == 12'h344);
   // Cycles since the last accepted start; saturates so idle time never wraps
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         since_q <= 16'hFFFF;
         pw_q <= 1'b0;
         rd_ctl_q <= 1'b0;
      end else begin
         if (wr_ctl && i_s_axi_wdata[5] && i_s_axi_wdata[4]) begin
            since_q <= 16'h0000;
         end else if (since_q != 16'hFFFF) begin
            since_q <= since_q + 16'h0001;
         end
         if (wr_ctl) begin
            pw_q <= i_s_axi_wdata[4];
         end
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            rd_ctl_q <= (i_s_axi_araddr == 12'h344);
         end
      end
   end

   // ========
   // Properties
   // ========
   reset_state_a: assert property ($fell(i_srst) |-> !o_irq && !o_conv_power && o_dac_code == 8'h00)
      else $error("outputs not idle after reset");
   power_follow_a: assert property (wr_ctl |=> o_conv_power == pw_q)
      else $error("power output does not follow control write");
   power_off_a: assert property (!o_conv_power [*3] |-> o_dac_code == 8'h00)
      else $error("trial code active while powered down");
   start_begins_a: assert property (wr_ctl && i_s_axi_wdata[5] && i_s_axi_wdata[4] |-> ##[1:4] o_dac_code == 8'h80)
      else $error("start did not launch a conversion");
   dac_step_a: assert property ($changed(o_dac_code) && o_dac_code == 8'h80 |-> ##[50:70] o_dac_code[6])
      else $error("second trial bit not reached in time");
   one_conv_a: assert property (since_q > 16'd600 && o_conv_power && $past(o_conv_power) |-> $stable(o_dac_code))
      else $error("conversion activity without a start");
   irq_late_a: assert property ($rose(o_irq) |-> since_q > 16'd550)
      else $error("interrupt before conversion could finish");
   ctrl_read_a: assert property (o_s_axi_rvalid && rd_ctl_q |-> o_s_axi_rdata[5] == 1'b0 && o_s_axi_rdata[3:0] == 4'h0)
      else $error("start or unused control bits read nonzero");
   read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
      else $error("read not answered next cycle");
endmodule // sac_top_props

bind sac_top sac_top_props u_props (
   .i_clk(i_clk),
   .i_srst(i_srst),
   .i_s_axi_awaddr(i_s_axi_awaddr),
   .i_s_axi_awvalid(i_s_axi_awvalid),
   .o_s_axi_awready(o_s_axi_awready),
   .i_s_axi_wdata(i_s_axi_wdata),
   .i_s_axi_wstrb(i_s_axi_wstrb),
   .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_s_axi_wready(o_s_axi_wready),
   .i_s_axi_araddr(i_s_axi_araddr),
   .i_s_axi_arvalid(i_s_axi_arvalid),
   .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rdata(o_s_axi_rdata),
   .o_s_axi_rvalid(o_s_axi_rvalid),
   .o_dac_code(o_dac_code),
   .o_conv_power(o_conv_power),
   .o_irq(o_irq)
);

//--- test_sar_adc_control.sv
// Self-checking bench for the SAR converter control block.
// Assumes the comparator model on the analog side and AXI4-Lite register access.
`timescale 1ns/1ps
module test_sar_adc_control
   import sac_pkg::*;
;
   localparam int CONV = int'(CONV_TICKS) * OSC_DIV;
   logic i_clk, i_srst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, comp_hi, conv_power, irq;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] dac_code, level;
   int fail_count, compares;

   // ========
   // Clock, design and partner
   // ========
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   sac_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
      .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .i_comp_hi(comp_hi), .o_dac_code(dac_code), .o_conv_power(conv_power), .o_irq(irq));
   sac_comp_model u_model (.i_clk(i_clk), .i_level(level), .i_dac_code(dac_code), .i_power(conv_power),
      .o_comp_hi(comp_hi));

   // ========
   // Bus and check tasks
   // ========
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Halves released one by one as taken; bready held until the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aw, w;
      int n;
      @(posedge i_clk);
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
         if (aw && awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while (!(bvalid && !aw && !w) && n < 100);
      bready <= 1'b0;
      check(32'({bvalid, bresp}), 32'({1'b1, RESP_OKAY}));
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge i_clk);
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      check(rdata, e);
      check(32'({rvalid, rresp}), 32'({1'b1, er}));
   endtask
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < CONV + 60) begin
         @(posedge i_clk);
         n++;
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ========
   // Scenarios
   // ========
   task automatic t_reset();
      check(32'(irq), 32'h0);
      check(32'(conv_power), 32'h0);
      rd_chk(12'h344, 32'h0000_0040, RESP_OKAY);
      rd_chk(12'h34C, 32'h0000_0001, RESP_OKAY);
      rd_chk(12'h350, 32'h0000_0000, RESP_SLVERR);
      $display("t_reset done");
   endtask
   task automatic t_convert();
      int n;
      level <= 8'hA5;
      wr(12'h344, 32'h0000_0090);
      check(32'(conv_power), 32'h1);
      wr(12'h344, 32'h0000_00B0);
      rd_chk(12'h344, 32'h0000_0090, RESP_OKAY);
      wait_irq(n);
      check(32'(n >= CONV - 8 && n <= CONV + 8), 32'h1);
      rd_chk(12'h340, 32'h0000_00A5, RESP_OKAY);
      rd_chk(12'h344, 32'h0000_00D0, RESP_OKAY);
      rd_chk(12'h348, 32'h0000_0001, RESP_OKAY);
      wr(12'h340, 32'h0000_0011);
      rd_chk(12'h340, 32'h0000_00A5, RESP_OKAY);
      wr(12'h348, 32'h0000_0001);
      repeat (3) @(posedge i_clk);
      check(32'(irq), 32'h0);
      repeat (CONV + 100) @(posedge i_clk);
      rd_chk(12'h348, 32'h0000_0000, RESP_OKAY);
      $display("t_convert done");
   endtask
   task automatic t_mask();
      level <= 8'h01;
      wr(12'h344, 32'h0000_0030);
      repeat (CONV + 20) @(posedge i_clk);
      check(32'(irq), 32'h0);
      rd_chk(12'h344, 32'h0000_0050, RESP_OKAY);
      rd_chk(12'h340, 32'h0000_0001, RESP_OKAY);
      wr(12'h344, 32'h0000_0090);
      repeat (3) @(posedge i_clk);
      check(32'(irq), 32'h1);
      wr(12'h348, 32'h0000_0001);
      $display("t_mask done");
   endtask
   task automatic t_restart();
      int n;
      level <= 8'h3C;
      wr(12'h344, 32'h0000_00B0);
      repeat (200) @(posedge i_clk);
      wr(12'h344, 32'h0000_00B0);
      repeat (400) @(posedge i_clk);
      check(32'(irq), 32'h0);
      rd_chk(12'h348, 32'h0000_0002, RESP_OKAY);
      wait_irq(n);
      check(32'(irq), 32'h1);
      rd_chk(12'h340, 32'h0000_003C, RESP_OKAY);
      wr(12'h348, 32'h0000_0003);
      $display("t_restart done");
   endtask
   task automatic t_power();
      wr(12'h344, 32'h0000_00B0);
      repeat (200) @(posedge i_clk);
      wr(12'h344, 32'h0000_0080);
      repeat (4) @(posedge i_clk);
      check(32'(conv_power), 32'h0);
      check(32'(dac_code), 32'h0);
      wr(12'h344, 32'h0000_00A0);
      repeat (CONV + 20) @(posedge i_clk);
      check(32'(dac_code), 32'h0);
      rd_chk(12'h348, 32'h0000_0000, RESP_OKAY);
      rd_chk(12'h344, 32'h0000_0080, RESP_OKAY);
      $display("t_power done");
   endtask
   // Reset in mid-conversion must abandon it: no late completion afterwards
   task automatic t_midreset();
      wr(12'h344, 32'h0000_00B0);
      repeat (100) @(posedge i_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      check(32'(dac_code), 32'h0);
      repeat (CONV) @(posedge i_clk);
      rd_chk(12'h348, 32'h0000_0000, RESP_OKAY);
      rd_chk(12'h344, 32'h0000_0040, RESP_OKAY);
      $display("t_midreset done");
   endtask

   // ========
   // Main sequence and watchdog
   // ========
   initial begin
      i_srst = 1'b1;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      level = 8'h00;
      fail_count = 0;
      compares = 0;
      repeat (16) @(posedge i_clk);
      i_srst <= 1'b0;
      t_reset();
      t_convert();
      t_mask();
      t_restart();
      t_power();
      t_midreset();
      conclude();
   end
   // Whole run is a few thousand cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      conclude();
   end
endmodule // test_sar_adc_control
